//--- common/rx_align_pkg.sv
// Constants for the receive word aligner: register map, fields, codes, times.
// Assumes one 50 MHz clock; shared by the aligner top and the deserializer.
package rx_align_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PATTERN_OFS = 8'h04;
	localparam logic [7:0] LOCK_OFS = 8'h08;
	localparam logic [7:0] TXCTL_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] DATA_OFS = 8'h14;
	// Control, lock and transmit control field positions
	localparam int CTRL_WIDTH10 = 0;
	localparam int CTRL_COMPL = 1;
	localparam int CTRL_PAT10 = 2;
	localparam int CTRL_ALIGN_EN = 3;
	localparam int CTRL_MODE_LO = 4;
	localparam int CTRL_RX_RST = 6;
	localparam int LOCK_REF = 0;
	localparam int LOCK_DATA = 1;
	localparam int LOCK_USED = 2;
	localparam int TX_PCIE = 0;
	localparam int TX_IDLE = 1;
	localparam int TX_DET = 2;
	// Reset values
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [9:0] PATTERN_RST = 10'h17c;
	localparam logic [2:0] LOCK_RST = 3'h0;
	localparam logic [1:0] TXCTL_RST = 2'h0;
	// Comma K28.5 (negative disparity form) in first-bit-in-LSB order
	localparam logic [9:0] COMMA_K285 = 10'h17c;
	localparam logic [9:0] MASK_10 = 10'h3ff;
	localparam logic [9:0] MASK_7 = 10'h07f;
	localparam logic [3:0] WIDTH_8 = 4'h8;
	localparam logic [3:0] WIDTH_10 = 4'ha;
	// Commas needed on one boundary before the protocol mode reports sync
	localparam logic [1:0] SYNC_NEED = 2'h3;
	// Timing
	localparam int CLK_MHZ = 50;
	localparam int PPM_SETTLE_NS = 1000;
	localparam int PPM_SETTLE_CYC = (PPM_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int DET_PULSE_NS = 2000;
	localparam int DET_PULSE_CYC = (DET_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SETTLE_LAST = 8'(PPM_SETTLE_CYC - 1);
	localparam logic [7:0] DET_LAST = 8'(DET_PULSE_CYC - 1);
	// Alignment modes
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'b00,
		MODE_AUTO = 2'b01,
		MODE_PRBS = 2'b10
	} align_mode_t;
	// Recovery unit lock modes
	typedef enum logic [1:0] {
		LOCK_TO_REF = 2'b00,
		LOCK_TO_DATA = 2'b01
	} lock_state_t;
	// Protocol sync states
	typedef enum logic [1:0] {
		SYNC_ACQ = 2'b00,
		SYNC_LOCKED = 2'b01
	} sync_state_t;
endpackage

//--- hdl/rx_word_aligner.sv
// Receive front end: lock mode choice, deserializer, word aligner, tx idle.
// Assumes clk runs at least at the bit rate, with serValid marking each bit, and an AHB-Lite master.
// Operation
// - Lock inputs choose reference, data or automatic
// - Unused lock inputs give automatic lock
// - Automatic mode switches on phase and ppm
// - Bit strobe feeds deserializer, same clock as the rest
// - First serial bit is the word LSB
// - Deserializer ignores symbol boundaries
// - Aligner runs on the same clock, once per word strobe
// - One programmable pattern, 7 or 10 bits
// - Exact match or pattern plus complement
// - Found pattern lands in output LSBs
// - Lowest, earliest match wins
// - Lock boundary, raise sync and detect
// - Protocol mode uses K28.5 and sync machine
// - Test mode adds K28.5 comma alignment to the programmed pattern
// - Force idle puts transmitter idle, PCIe only
// - Receiver detect only while transmitter idle
// - Manual lock gives one-cycle sync pulse
// - Detect pulses on alignment and repeated pattern
`timescale 1ns/1ps
module rx_word_aligner (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial input, one recovered bit per strobe
	input wire logic serBit,
	input wire logic serValid,
	// Recovery unit detectors
	input wire logic ppmInRange,
	input wire logic phaseLocked,
	output logic lockToData,
	// Aligned parallel output
	output logic [9:0] alignedWord,
	output logic alignedValid,
	output logic syncStatus,
	output logic patternDetect,
	// Transmitter idle and receiver detect
	output logic txElecIdle,
	output logic detPulse,
	input wire logic detSense
);
	import rx_align_pkg::*;

	// Software registers
	logic [6:0] ctrl_reg; // Width, complement, pattern size, enable, mode, reset
	logic [9:0] pattern_reg; // Programmed pattern, first bit in LSB
	logic [2:0] lock_reg; // Manual lock bits and in-use flag
	logic [1:0] txctl_reg; // PCIe mode and force idle
	// Bus data phase
	logic wrPend_reg; // Write awaiting its data phase
	logic [7:0] wrAddr_reg; // Address of that write
	// Aligner state
	logic [9:0] prev_reg; // Previous word, the older half of the window
	logic [3:0] boundary_reg; // Locked bit offset
	logic aligned_reg; // Boundary has been locked
	sync_state_t sync_reg; // Protocol sync state
	logic [1:0] commaCnt_reg; // Commas seen on the boundary
	// Recovery unit lock
	lock_state_t lock_reg2; // Automatic mode state
	logic [7:0] settle_reg; // Cycles the ppm detector stayed good
	// Receiver detect
	logic [7:0] detCnt_reg; // Pulse cycle count
	logic detPresent_reg; // Last detect result
	// Combinational
	logic [9:0] parWord; // Deserializer output
	logic parValid;
	logic [19:0] window; // Previous and current word joined
	logic [9:0] matchVec; // One bit per candidate offset
	logic [9:0] matchPat, matchMask;
	logic matchCompl, found, onBoundary, width10;
	logic [3:0] firstHit;
	align_mode_t mode;
	logic rxReset, wrEn;
	logic [19:0] shifted;
	logic lockNow, syncGain; // New boundary taken, protocol sync reached
	logic [3:0] useBound; // Shift used for the word now leaving

	assign width10 = ctrl_reg[CTRL_WIDTH10];
	assign mode = align_mode_t'(ctrl_reg[CTRL_MODE_LO +: 2]);
	assign rxReset = srst || ctrl_reg[CTRL_RX_RST];
	assign hreadyout = 1'b1; // Zero wait states; every access completes
	assign hresp = 1'b0; // Always OKAY
	assign wrEn = wrPend_reg && hready;

	// Deserializer on the recovered bit strobe; words leave unaligned
	ser_to_par u_deser (
		.clk(clk),
		.srst(srst),
		.serBit(serBit),
		.serValid(serValid),
		.width10(width10),
		.parWord(parWord),
		.parValid(parValid)
	);

	// Address phase capture for writes
	always_ff @(posedge clk) begin
		if (srst) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= '0;
		end else if (hready) begin
			wrPend_reg <= hsel && htrans[1] && hwrite;
			wrAddr_reg <= haddr;
		end
	end

	// Register writes in the data phase; patterns are LSB first
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg <= CTRL_RST;
			pattern_reg <= PATTERN_RST;
			lock_reg <= LOCK_RST;
			txctl_reg <= TXCTL_RST;
		end else if (wrEn) begin
			unique case (wrAddr_reg)
				CTRL_OFS: ctrl_reg <= hwdata[6:0];
				PATTERN_OFS: pattern_reg <= hwdata[9:0];
				LOCK_OFS: lock_reg <= hwdata[2:0];
				TXCTL_OFS: txctl_reg <= hwdata[1:0];
				default: ; // Unmapped or read-only: ignored
			endcase
		end
	end

	// Read data loaded at the address phase, so it stands in the data phase
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				CTRL_OFS: hrdata <= {25'h0, ctrl_reg};
				PATTERN_OFS: hrdata <= {22'h0, pattern_reg};
				LOCK_OFS: hrdata <= {29'h0, lock_reg};
				TXCTL_OFS: hrdata <= {30'h0, txctl_reg};
				STATUS_OFS: hrdata <= {20'h0, aligned_reg, detPresent_reg,
					detPulse, txElecIdle, 1'b0, lockToData, boundary_reg,
					patternDetect, syncStatus};
				DATA_OFS: hrdata <= {22'h0, alignedWord};
				default: hrdata <= '0;
			endcase
		end
	end

	// Pattern choice: protocol mode forces the comma with its complement
	always_comb begin
		if (mode == MODE_AUTO) begin
			matchPat = COMMA_K285;
			matchMask = MASK_10;
			matchCompl = 1'b1;
		end else begin
			matchPat = pattern_reg;
			matchMask = ctrl_reg[CTRL_PAT10] ? MASK_10 : MASK_7;
			matchCompl = ctrl_reg[CTRL_COMPL];
		end
	end

	// Older word in the low half, so a lower offset means received earlier
	assign window = width10 ? {parWord, prev_reg}
		: {4'h0, parWord[7:0], prev_reg[7:0]};

	// One comparator per candidate offset
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_match
			logic [9:0] slice;
			logic hitPat, hitK;
			assign slice = window[gi +: 10] & matchMask;
			assign hitPat = (slice == (matchPat & matchMask)) ||
				(matchCompl && slice == (~matchPat & matchMask));
			// Test mode also aligns on 8b/10b commas either polarity
			assign hitK = (mode == MODE_PRBS) && ((window[gi +: 10] == COMMA_K285)
				|| (window[gi +: 10] == ~COMMA_K285));
			assign matchVec[gi] = (width10 || gi < 8) && (hitPat || hitK);
		end
	endgenerate

	// Scan down from offset 9; the last hit, at the lowest offset, wins
	always_comb begin
		firstHit = '0;
		found = 1'b0;
		for (int i = 9; i >= 0; i--) begin
			if (matchVec[i]) begin
				firstHit = 4'(i);
				found = 1'b1;
			end
		end
	end

	assign onBoundary = matchVec[boundary_reg];

	// New lock this word: manual needs the enable, protocol mode ignores it
	assign lockNow = parValid && found && !(aligned_reg && onBoundary) &&
		(mode == MODE_AUTO ? sync_reg == SYNC_ACQ : ctrl_reg[CTRL_ALIGN_EN]);

	// Last needed comma on the boundary; sync rises with that word's strobe
	assign syncGain = parValid && (mode == MODE_AUTO) && (sync_reg == SYNC_ACQ) && found
		&& aligned_reg && (firstHit == boundary_reg) && (commaCnt_reg == SYNC_NEED - 2'h1);

	// Previous word keeps the window filled
	always_ff @(posedge clk) begin
		if (rxReset) begin
			prev_reg <= '0;
		end else if (parValid) begin
			prev_reg <= parWord;
		end
	end

	// Boundary lock: manual needs the enable, protocol mode ignores it
	always_ff @(posedge clk) begin
		if (rxReset) begin
			boundary_reg <= '0;
			aligned_reg <= 1'b0;
		end else if (lockNow) begin
			boundary_reg <= firstHit;
			aligned_reg <= 1'b1;
		end
	end

	// Protocol sync machine: enough commas on one boundary gives sync
	always_ff @(posedge clk) begin
		if (rxReset || mode != MODE_AUTO) begin
			sync_reg <= SYNC_ACQ;
			commaCnt_reg <= '0;
		end else if (parValid) begin
			unique case (sync_reg)
				SYNC_ACQ: begin
					if (found && aligned_reg && firstHit == boundary_reg) begin
						if (commaCnt_reg == SYNC_NEED - 2'h1) begin
							sync_reg <= SYNC_LOCKED;
						end
						commaCnt_reg <= commaCnt_reg + 2'h1;
					end else if (found) begin
						commaCnt_reg <= 2'h1; // New boundary, count restarts
					end
				end
				SYNC_LOCKED: ; // Held until receive reset or a mode change
			endcase
		end
	end

	// Output shift puts the boundary (and the pattern) in the LSBs
	// The locking word already uses the new offset, so detect carries the pattern
	assign useBound = lockNow ? firstHit : boundary_reg;
	assign shifted = window >> useBound;

	// Aligned data, sync and detect; data lag the word by one cycle
	always_ff @(posedge clk) begin
		if (rxReset) begin
			alignedWord <= '0;
			alignedValid <= 1'b0;
			syncStatus <= 1'b0;
			patternDetect <= 1'b0;
		end else begin
			alignedValid <= parValid;
			if (parValid) begin
				alignedWord <= width10 ? shifted[9:0] : {2'h0, shifted[7:0]};
			end
			// New lock or pattern on the current boundary
			patternDetect <= lockNow || (parValid && aligned_reg && onBoundary);
			if (mode == MODE_AUTO) begin
				syncStatus <= (sync_reg == SYNC_LOCKED) || syncGain;
			end else begin
				// One-cycle pulse on lock, or resync hint when not enabled
				syncStatus <= parValid && found && !(aligned_reg && onBoundary);
			end
		end
	end

	// Recovery unit lock: manual bits, or ppm and phase decide
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_reg2 <= LOCK_TO_REF;
			settle_reg <= '0;
		end else begin
			unique case (lock_reg2)
				LOCK_TO_REF: begin
					// Data lock only after the frequency stays in range
					if (!ppmInRange) begin
						settle_reg <= '0;
					end else if (settle_reg == SETTLE_LAST) begin
						lock_reg2 <= LOCK_TO_DATA;
						settle_reg <= '0;
					end else begin
						settle_reg <= settle_reg + 8'h1;
					end
				end
				LOCK_TO_DATA: begin
					if (!ppmInRange || !phaseLocked) begin
						lock_reg2 <= LOCK_TO_REF;
					end
				end
			endcase
		end
	end

	// Force data beats force reference; unused bits fall back to automatic
	always_comb begin
		if (lock_reg[LOCK_USED] && lock_reg[LOCK_DATA]) begin
			lockToData = 1'b1;
		end else if (lock_reg[LOCK_USED] && lock_reg[LOCK_REF]) begin
			lockToData = 1'b0;
		end else begin
			lockToData = (lock_reg2 == LOCK_TO_DATA);
		end
	end

	// Electrical idle only honoured in PCIe mode
	assign txElecIdle = txctl_reg[TX_PCIE] && txctl_reg[TX_IDLE];

	// Receiver detect: start ignored unless the transmitter is idle
	always_ff @(posedge clk) begin
		if (srst) begin
			detCnt_reg <= '0;
			detPulse <= 1'b0;
			detPresent_reg <= 1'b0;
		end else if (detPulse) begin
			if (detCnt_reg == DET_LAST || !txElecIdle) begin
				detPulse <= 1'b0;
				detPresent_reg <= detSense && txElecIdle; // Reflection sample
			end
			detCnt_reg <= detCnt_reg + 8'h1;
		end else if (wrEn && wrAddr_reg == TXCTL_OFS && hwdata[TX_DET] && txElecIdle
			&& hwdata[TX_PCIE] && hwdata[TX_IDLE]) begin
			detPulse <= 1'b1;
			detCnt_reg <= '0;
		end
	end
endmodule

//--- hdl/ser_to_par.sv
// Deserializer: gathers serial bits into 8- or 10-bit words.
// Assumes serial bits arrive one per qualified clock, synchronous to clk.
`timescale 1ns/1ps
module ser_to_par (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Serial side
	input wire logic serBit,
	input wire logic serValid,
	input wire logic width10,
	// Parallel side
	output logic [9:0] parWord,
	output logic parValid
);
	import rx_align_pkg::*;

	logic [9:0] shift_reg; // Newest bit enters at the top
	logic [3:0] count_reg; // Bits gathered so far
	logic [3:0] width; // Word length in bits
	logic wordEnd; // Last bit of a word arrives

	assign width = width10 ? WIDTH_10 : WIDTH_8;
	// A count left above a new, shorter width wraps at once, not after 16 bits
	assign wordEnd = serValid && (count_reg >= width - 4'h1);

	// Shift in, first bit ends up least significant; no boundary search here
	always_ff @(posedge clk) begin
		if (srst) begin
			shift_reg <= '0;
			count_reg <= '0;
		end else if (serValid) begin
			shift_reg <= {serBit, shift_reg[9:1]};
			if (wordEnd) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + 4'h1;
			end
		end
	end

	// Word out when the count wraps; 8-bit words sit in the lower eight
	always_ff @(posedge clk) begin
		if (srst) begin
			parWord <= '0;
			parValid <= 1'b0;
		end else begin
			parValid <= wordEnd;
			if (wordEnd) begin
				if (width10) begin
					parWord <= {serBit, shift_reg[9:1]};
				end else begin
					parWord <= {2'h0, serBit, shift_reg[9:3]};
				end
			end
		end
	end
endmodule

//--- test/rx_word_aligner_chk.sv
// Checker for the receive aligner: pulses, reset, receiver detect.
// Assumes it sees only the top ports; bound at the foot.
`timescale 1ns/1ps
module rx_word_aligner_chk
	import rx_align_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Watched ports
	input wire logic [31:0] hrdata,
	input wire logic serValid,
	input wire logic alignedValid,
	input wire logic syncStatus,
	input wire logic patternDetect,
	input wire logic txElecIdle,
	input wire logic detPulse
);
	// Cycles the detect pulse has stood
	logic [7:0] detCnt;
	// Counter restarts whenever the pulse is low
	always_ff @(posedge clk) begin
		if (srst || !detPulse) begin
			detCnt <= 8'h00;
		end else begin
			detCnt <= detCnt + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	AST_RST_CLEAR: assert property ($past(srst) |->
		!alignedValid && !patternDetect && !syncStatus && hrdata == 32'h0)
		else $error("outputs not clear after reset");
	AST_VALID_CAUSE: assert property (alignedValid |-> $past(serValid, 2))
		else $error("word without a bit two cycles before");
	AST_VALID_PULSE: assert property (alignedValid |=> !alignedValid)
		else $error("word strobe longer than one cycle");
	AST_PD_WORD: assert property (patternDetect |-> alignedValid)
		else $error("detect without a word");
	AST_PD_PULSE: assert property (patternDetect |=> !patternDetect)
		else $error("detect longer than one cycle");
	AST_SYNC_WORD: assert property ($rose(syncStatus) |-> alignedValid)
		else $error("sync rose without a word");
	AST_DET_IDLE: assert property ($rose(detPulse) |-> $past(txElecIdle))
		else $error("detect pulse outside idle");
	AST_DET_MAX: assert property (detPulse |-> detCnt <= DET_LAST)
		else $error("detect pulse too long");
	AST_DET_LEN: assert property ($fell(detPulse) && txElecIdle |->
		detCnt == DET_LAST + 8'h01)
		else $error("detect pulse too short");
	// Main scenarios reached
	cover property (patternDetect && syncStatus);
	cover property ($fell(detPulse));
	cover property (syncStatus [*3]);
endmodule
bind rx_word_aligner rx_word_aligner_chk chk (.clk(clk), .srst(srst), .hrdata(hrdata),
	.serValid(serValid), .alignedValid(alignedValid), .syncStatus(syncStatus),
	.patternDetect(patternDetect), .txElecIdle(txElecIdle), .detPulse(detPulse));

//--- test/rx_word_aligner_tb_top.sv
// Testbench: lock choice, tx idle, alignment cases, detect, reset.
// Assumes the checker and serial model are compiled before it.
`timescale 1ns/1ps
module rx_word_aligner_tb_top;
	import rx_align_pkg::*;
	// Stimulus and observed ports
	logic clk, srst, hsel, hwrite, hreadyout, hresp, pdSeen;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic serBit, serValid, ppmInRange, phaseLocked, lockToData, detSense;
	logic [9:0] alignedWord, pdWord;
	logic alignedValid, syncStatus, patternDetect, txElecIdle, detPulse;
	int n_mismatch, n_checks, syncCnt;
	// Register write and expected {idle, lockToData}
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] e;} row_t;
	row_t rows[6] = '{'{LOCK_OFS, 32'h5, 2'h0}, '{LOCK_OFS, 32'h6, 2'h1},
		'{LOCK_OFS, 32'h7, 2'h1}, '{TXCTL_OFS, 32'h3, 2'h3},
		'{TXCTL_OFS, 32'h2, 2'h1}, '{TXCTL_OFS, 32'h1, 2'h1}};
	rx_word_aligner DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.serBit(serBit), .serValid(serValid), .ppmInRange(ppmInRange),
		.phaseLocked(phaseLocked), .lockToData(lockToData), .alignedWord(alignedWord),
		.alignedValid(alignedValid), .syncStatus(syncStatus),
		.patternDetect(patternDetect), .txElecIdle(txElecIdle), .detPulse(detPulse),
		.detSense(detSense));
	ser_tx_model tx (.clk(clk), .serBit(serBit), .serValid(serValid));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// First detect of a case and its word; sync cycles counted
	always @(posedge clk) begin
		if (patternDetect === 1'b1 && !pdSeen) begin
			pdSeen <= 1'b1;
			pdWord <= alignedWord;
		end
		if (syncStatus === 1'b1) syncCnt <= syncCnt + 1;
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bounded wait for hready at a rising edge
	task automatic waitRdy;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
	endtask
	// One single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		waitRdy();
		htrans <= 2'b00;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
	endtask
	// Pattern behind three stray zeros, then zero flush; s below 0 skips sync count
	task automatic alignCase(input logic [6:0] c, input logic [9:0] p,
		input logic [29:0] w, input int n, input logic [9:0] m, input logic pd, input int s);
		bus(1'b1, CTRL_OFS, {25'h0, c} | 32'h40);
		bus(1'b1, PATTERN_OFS, {22'h0, p});
		bus(1'b1, CTRL_OFS, {25'h0, c});
		pdSeen <= 1'b0;
		syncCnt <= 0;
		tx.push(30'h0, 3);
		tx.push(w, n);
		tx.push(30'h0, 30);
		for (int i = 0; i < 200 && tx.q.size() > 0; i++) @(posedge clk);
		chk("drain", tx.q.size(), 32'h0);
		tick(4);
		chk("detect", pdSeen, pd);
		if (pd) chk("word", pdWord & m, w[9:0] & m);
		if (s >= 0) chk("sync", syncCnt, s);
		$display("align case %h done", c);
	endtask
	initial begin
		srst = 1'b1;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwdata = 32'h0;
		ppmInRange = 1'b0;
		phaseLocked = 1'b0;
		detSense = 1'b0;
		pdSeen = 1'b0;
		pdWord = 10'h000;
		syncCnt = 0;
		tick(20);
		srst <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			bus(1'b1, rows[k].a, rows[k].d);
			tick(1);
			chk("ports", {txElecIdle, lockToData}, rows[k].e);
		end
		$display("table done");
		// Automatic lock follows the detectors
		bus(1'b1, LOCK_OFS, 32'h0);
		ppmInRange <= 1'b1;
		phaseLocked <= 1'b1;
		tick(60);
		chk("autoData", lockToData, 1'b1);
		ppmInRange <= 1'b0;
		tick(3);
		chk("autoRef", lockToData, 1'b0);
		// Receiver detect while idle, then refused when not idle
		detSense <= 1'b1;
		bus(1'b1, TXCTL_OFS, 32'h3);
		bus(1'b1, TXCTL_OFS, 32'h7);
		tick(2);
		chk("detOn", detPulse, 1'b1);
		for (int k = 0; k < 200 && detPulse === 1'b1; k++) @(posedge clk);
		chk("detEnd", detPulse, 1'b0);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk("present", rd[10], 1'b1);
		bus(1'b1, TXCTL_OFS, 32'h5);
		tick(1);
		chk("noDet", detPulse, 1'b0);
		$display("detect done");
		alignCase(7'h0d, COMMA_K285, 30'h17c, 10, MASK_10, 1'b1, 1);
		alignCase(7'h0f, COMMA_K285, 30'h283, 10, MASK_10, 1'b1, 1);
		alignCase(7'h0d, COMMA_K285, 30'h283, 10, MASK_10, 1'b0, 0);
		alignCase(7'h08, 10'h05b, 30'h5b, 8, MASK_7, 1'b1, 1);
		alignCase(7'h05, COMMA_K285, 30'h17c, 10, MASK_10, 1'b0, 1);
		alignCase(7'h2d, 10'h0f0, 30'h0f0, 10, MASK_10, 1'b1, 1);
		alignCase(7'h11, 10'h000, {3{COMMA_K285}}, 30, MASK_10, 1'b1, -1);
		chk("protoSync", syncStatus, 1'b1);
		// Mid-run reset clears state and registers
		srst <= 1'b1;
		tick(20);
		srst <= 1'b0;
		chk("syncRst", syncStatus, 1'b0);
		bus(1'b0, PATTERN_OFS, 32'h0);
		chk("patRst", rd, {22'h0, PATTERN_RST});
		bus(1'b0, LOCK_OFS, 32'h0);
		chk("lockRst", rd, 32'h0);
		bus(1'b0, 8'h3c, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("reset done");
		conclude();
	end
endmodule

//--- test/ser_tx_model.sv
// Remote serial transmitter: sends queued bits, lowest bit first.
// Assumes one bit per clock, changed just after the rising edge.
`timescale 1ns/1ps
module ser_tx_model (
	// Clock
	input wire logic clk,
	// Serial line
	output logic serBit,
	output logic serValid
);
	// Bits waiting, oldest in front
	logic q[$];
	initial begin
		serBit = 1'b0;
		serValid = 1'b0;
	end
	// Queue n bits of a word
	task automatic push(input logic [29:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			q.push_back(w[i]);
		end
	endtask
	// Idle line toggles so a stale bit never looks valid
	always @(posedge clk) begin
		if (q.size() > 0) begin
			serValid <= 1'b1;
			serBit <= q.pop_front();
		end else begin
			serValid <= 1'b0;
			serBit <= ~serBit;
		end
	end
endmodule
